//--- rtl/tsrf_top.sv
// sensor register file with serial slave, pointer and conversion timer
`timescale 1ns/1ps
`include "tsrf_regs.svh"
module tsrf_top
  import tsrf_pkg::*;
#(
  parameter logic [5:0] BUS_ADDR_HI = 6'h15,  // arbitrary upper address bits, low bit is strap
  parameter int CONV_CYC = `TSRF_TS_TYP_MS * `TSRF_CLK_KHZ,
  parameter int PER0_CYC = `TSRF_PER_R0_MS * `TSRF_CLK_KHZ,
  parameter int PER1_CYC = `TSRF_PER_R1_MS * `TSRF_CLK_KHZ,
  parameter int PER2_CYC = `TSRF_PER_R2_MS * `TSRF_CLK_KHZ,
  parameter int PER3_CYC = `TSRF_PER_R3_MS * `TSRF_CLK_KHZ
) (
  input  wire logic        sys_clk_i,     // 40 MHz device clock
  input  wire logic        rst_n_i,       // power-on reset, active low
  input  wire logic        scl_i,         // serial clock pin
  input  wire logic        sda_i,         // serial data pin level
  output logic             sda_o,         // serial data drive value
  output logic             sda_oe_o,      // serial data drive enable
  input  wire logic        addr_sel_i,    // address select strap pin
  input  wire logic [15:0] adc_result_i,  // converter result, same clock
  input  wire logic        thr_flag_i,    // comparator flag, same clock
  output tsrf_setup_t      setup_o,       // setup register fields
  output logic      [15:0] low_limit_o,   // low limit register
  output logic      [15:0] high_limit_o,  // high limit register
  output logic             conv_busy_o    // conversion in progress
);
  logic [2:0]  pins_f;
  logic        scl_f, sda_f, add_f, scl_p_q, sda_p_q;
  logic        scl_rise, scl_fall, start_c, stop_c;
  tsrf_state_t st_q, st_d;
  logic [7:0]  sr_q, sr_d, tx_q, tx_d, msb_q, msb_d;
  logic [3:0]  bit_q, bit_d;
  logic [2:0]  byte_q, byte_d;
  logic        rw_q, rw_d, hi_q, hi_d, nack_q, nack_d, oe_d;
  logic [1:0]  ptr_q, ptr_d;
  logic [15:0] rdw_q, rdw_d, low_d, high_d, temp_q, temp_d;
  tsrf_setup_t setup_d;
  logic        busy_d, first_q, first_d;
  logic        ld_tx, ss_wr;
  logic [31:0] tmr_q, tmr_d, per_cyc;

  // open-drain data: only ever pull low
  assign sda_o = 1'b0;

  tsrf_sync #(.W(3), .RST_VAL(3'h3)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     ({addr_sel_i, sda_i, scl_i}),
    .lvl_o     (pins_f)
  );
  assign scl_f    = pins_f[0];
  assign sda_f    = pins_f[1];
  assign add_f    = pins_f[2];
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_c  = scl_f & scl_p_q & ~sda_f & sda_p_q;
  assign stop_c   = scl_f & scl_p_q & sda_f & ~sda_p_q;

  // word of the register the pointer selects
  function automatic logic [15:0] sel_word(input logic [1:0] p, input tsrf_setup_t s,
      input logic [15:0] t, input logic [15:0] lo, input logic [15:0] hi);
    unique case (p)
      `TSRF_PTR_TEMP:  sel_word = t;        // RULE3
      `TSRF_PTR_SETUP: sel_word = s;
      `TSRF_PTR_LOW:   sel_word = lo;
      default:         sel_word = hi;
    endcase
  endfunction

  // conversion period from the rate field
  always_comb begin
    unique case (setup_o.sample_rate_field)
      `TSRF_RATE_R0: per_cyc = PER0_CYC;    // RULE11
      `TSRF_RATE_R1: per_cyc = PER1_CYC;
      `TSRF_RATE_R2: per_cyc = PER2_CYC;
      default:       per_cyc = PER3_CYC;
    endcase
  end

  // serial slave, pointer and register writes
  always_comb begin
    st_d = st_q; sr_d = sr_q; tx_d = tx_q; msb_d = msb_q; bit_d = bit_q;
    byte_d = byte_q; rw_d = rw_q; hi_d = hi_q; nack_d = nack_q; oe_d = sda_oe_o;
    ptr_d = ptr_q; rdw_d = rdw_q; low_d = low_limit_o; high_d = high_limit_o;
    setup_d = setup_o;
    ld_tx = 1'b0;
    ss_wr = 1'b0;
    setup_d.threshold_flag = thr_flag_i;    // RULE7
    unique case (st_q)
      TS_IDLE: ;
      TS_RX: begin
        if (scl_rise) begin
          sr_d  = {sr_q[6:0], sda_f};
          bit_d = bit_q + 4'h1;
        end else if (scl_fall && bit_q == `TSRF_BITS_BYTE) begin
          if (byte_q == `TSRF_BYTE_ADDR) begin
            if (sr_q[7:1] == {BUS_ADDR_HI, add_f}) begin
              rw_d = sr_q[0]; oe_d = 1'b1; st_d = TS_ACK; hi_d = 1'b1;
            end else begin
              st_d = TS_IDLE;
            end
          end else begin
            oe_d = 1'b1; st_d = TS_ACK;
            if (byte_q == `TSRF_BYTE_PTR) begin
              ptr_d = sr_q[1:0];            // RULE1 RULE2 RULE13
            end else if (hi_q) begin
              msb_d = sr_q;                 // RULE6
              hi_d  = 1'b0;
            end else begin
              hi_d = 1'b1;
              unique case (ptr_q)
                `TSRF_PTR_TEMP: ;           // RULE4
                `TSRF_PTR_SETUP: setup_d = tsrf_setup_t'(
                    ({msb_q, sr_q} & `TSRF_SETUP_WMASK) |
                    (`TSRF_SETUP_FIXED & ~`TSRF_SETUP_WMASK));  // RULE9
                `TSRF_PTR_LOW:  low_d  = {msb_q, sr_q};
                default:        high_d = {msb_q, sr_q};
              endcase
              // single shot only takes effect in sleep
              if (ptr_q == `TSRF_PTR_SETUP) begin
                setup_d.single_shot = msb_q[7] & msb_q[0];
                ss_wr = msb_q[7] & msb_q[0];
                setup_d.threshold_flag = thr_flag_i;
              end
            end
          end
          if (byte_q != 3'h7) begin
            byte_d = byte_q + 3'h1;
          end
        end
      end
      TS_ACK: if (scl_fall) begin
        bit_d = 4'h0;
        if (rw_q) begin
          ld_tx = 1'b1;
        end else begin
          oe_d = 1'b0; st_d = TS_RX;
        end
      end
      TS_TX: if (scl_fall) begin
        if (bit_q == `TSRF_BITS_BYTE) begin
          oe_d = 1'b0; st_d = TS_RACK;
        end else begin
          tx_d = {tx_q[6:0], 1'b0}; oe_d = ~tx_q[6]; bit_d = bit_q + 4'h1;
        end
      end
      TS_RACK: begin
        if (scl_rise) begin
          nack_d = sda_f;
        end else if (scl_fall) begin
          // a host ack launches the next byte on this very fall, not one bit later
          if (nack_q) begin
            st_d = TS_IDLE;
          end else begin
            ld_tx = 1'b1;
          end
        end
      end
      default: st_d = TS_IDLE;
    endcase
    // load and drive the first bit of the next read byte
    if (ld_tx) begin
      if (hi_q) begin
        rdw_d = sel_word(ptr_q, setup_o, temp_q, low_limit_o, high_limit_o);
        tx_d  = rdw_d[15:8];                // RULE6
      end else begin
        tx_d = rdw_q[7:0];
      end
      hi_d  = ~hi_q;
      oe_d  = ~tx_d[7];
      bit_d = 4'h1;
      st_d  = TS_TX;
    end
    // start and stop override any state; a stop frees the line
    if (start_c) begin
      st_d = TS_RX; bit_d = 4'h0; byte_d = `TSRF_BYTE_ADDR; oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = TS_IDLE; oe_d = 1'b0;
    end
    // hardware clear of single shot, a same-cycle host set wins
    if (conv_busy_o && tmr_q == 32'(CONV_CYC - 1) && !ss_wr) begin
      setup_d.single_shot = 1'b0;
    end
  end

  // conversion timer; starts at once after reset
  always_comb begin
    busy_d = conv_busy_o; tmr_d = tmr_q + 32'h1; temp_d = temp_q; first_d = first_q;
    if (conv_busy_o) begin
      if (tmr_q == 32'(CONV_CYC - 1)) begin       // RULE12
        busy_d = 1'b0; tmr_d = 32'(CONV_CYC); temp_d = adc_result_i; first_d = 1'b1;
      end
    end else if (setup_o.sleep_select) begin
      tmr_d = 32'h0;
      busy_d = setup_o.single_shot;
    end else if (tmr_q >= per_cyc - 32'h1) begin  // RULE11
      busy_d = 1'b1; tmr_d = 32'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= TS_IDLE; sr_q <= 8'h00; tx_q <= 8'h00; msb_q <= 8'h00; bit_q <= 4'h0;
      byte_q <= 3'h0; rw_q <= 1'b0; hi_q <= 1'b1; nack_q <= 1'b0; sda_oe_o <= 1'b0;
      ptr_q <= `TSRF_PTR_TEMP; rdw_q <= 16'h0000;
      setup_o <= tsrf_setup_t'(`TSRF_SETUP_RST);   // RULE8
      low_limit_o <= `TSRF_LOW_RST;                 // RULE14
      high_limit_o <= `TSRF_HIGH_RST;
      temp_q <= `TSRF_TEMP_RST; first_q <= 1'b0;
      conv_busy_o <= 1'b1; tmr_q <= 32'h0;
      scl_p_q <= 1'b1; sda_p_q <= 1'b1;
    end else begin
      st_q <= st_d; sr_q <= sr_d; tx_q <= tx_d; msb_q <= msb_d; bit_q <= bit_d;
      byte_q <= byte_d; rw_q <= rw_d; hi_q <= hi_d; nack_q <= nack_d; sda_oe_o <= oe_d;
      ptr_q <= ptr_d; rdw_q <= rdw_d; setup_o <= setup_d;
      low_limit_o <= low_d; high_limit_o <= high_d;
      temp_q <= temp_d; first_q <= first_d; conv_busy_o <= busy_d; tmr_q <= tmr_d;
      scl_p_q <= scl_f; sda_p_q <= sda_f;
    end
  end

  // checks
  chk_setup_fixed: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE9
    (setup_o.rsv_hi == 2'h2) && (setup_o.rsv_lo == 4'h0))
    else $error("reserved setup bits moved");
  chk_temp_ro: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE4
    $changed(temp_q) |-> $past(conv_busy_o) && !conv_busy_o)
    else $error("temperature changed outside a conversion end");
  chk_ptr_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE13
    $changed(ptr_q) |-> $past(st_q) == TS_RX && st_q == TS_ACK && $past(byte_q) == 3'h1)
    else $error("pointer changed outside a pointer byte");
  chk_ptr_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE2
    $changed(ptr_q) |-> ptr_q == $past(sr_q[1:0]))
    else $error("pointer not taken from low bits");
  chk_sel_map: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE3
    (st_q == TS_ACK && scl_fall && rw_q && hi_q && ptr_q == `TSRF_PTR_SETUP)
    |=> tx_q == setup_o[15:8] || $changed(setup_o))
    else $error("setup upper byte not sent first");
  chk_first_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE14
    !first_q |-> temp_q == `TSRF_TEMP_RST)
    else $error("temperature nonzero before first result");
  chk_conv_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE12
    $fell(conv_busy_o) |-> $past(tmr_q) == 32'(CONV_CYC - 1))
    else $error("conversion length wrong");
  chk_ss_ends: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE7
    $fell(conv_busy_o) && !$past(ss_wr) |-> !setup_o.single_shot)
    else $error("single shot not cleared at conversion end");
  chk_period: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)  // RULE11
    $rose(conv_busy_o) && !setup_o.sleep_select |-> $past(tmr_q) >= $past(per_cyc) - 32'h1)
    else $error("conversion started early");
endmodule

//--- rtl/tsrf_regs.svh
// register map, field layout, reset values and timing figures of the sensor register file
// Behaviour
// RULE1: an eight-bit pointer register whose two low bits choose the data register for the next access.
// RULE2: pointer bits seven to two always read as zero and ignore writes.
// RULE3: pointer 0 selects the temperature result, 1 the setup, 2 the low limit, 3 the high limit.
// RULE4: the temperature result is read-only while setup and both limits are read-write.
// RULE5: the host loads the pointer before reading or writing a data register.
// RULE6: the sixteen-bit setup register moves upper byte first on every read and write.
// RULE7: setup holds single-shot 15, fault count 12-11, alert sense 10, latch 9, sleep 8, rate 7-6, flag 5.
// RULE8: after reset setup bits 14, 7 and 5 are one and all others are zero.
// RULE9: setup bits 3-0 and 14-13 are reserved, read-only and keep their defaults.
// RULE10: the host always writes setup bit 4 as zero.
// RULE11: rate codes 00, 01, 10, 11 give 0.25, 1, 4 and 8 conversions per second, default 250 ms.
// RULE12: conversion starts at once after reset and the first result comes after 34 ms, before 46 ms.
// RULE13: the pointer keeps its value between transactions.
// RULE14: limits reset to fixed values and the temperature reads zero until the first conversion ends.
`ifndef TSRF_REGS_SVH
`define TSRF_REGS_SVH

`define TSRF_PTR_TEMP     2'h0
`define TSRF_PTR_SETUP    2'h1
`define TSRF_PTR_LOW      2'h2
`define TSRF_PTR_HIGH     2'h3
`define TSRF_PTR_RD_MASK  8'h03
`define TSRF_SETUP_RST    16'h40a0
`define TSRF_SETUP_WMASK  16'h9fd0
`define TSRF_SETUP_FIXED  16'h4000
`define TSRF_LOW_RST      16'h4b00
`define TSRF_HIGH_RST     16'h5000
`define TSRF_TEMP_RST     16'h0000
`define TSRF_BYTE_ADDR    3'h0
`define TSRF_BYTE_PTR     3'h1
`define TSRF_BITS_BYTE    4'h8
`define TSRF_CLK_KHZ      40000
`define TSRF_TS_TYP_MS    34
`define TSRF_TS_MAX_MS    46
`define TSRF_PER_R0_MS    4000
`define TSRF_PER_R1_MS    1000
`define TSRF_PER_R2_MS    250
`define TSRF_PER_R3_MS    125
`define TSRF_RATE_R0      2'h0
`define TSRF_RATE_R1      2'h1
`define TSRF_RATE_R2      2'h2

`endif

//--- rtl/tsrf_pkg.sv
// types shared by the sensor register file
package tsrf_pkg;

  // setup register layout, bit 15 down to bit 0
  typedef struct packed {
    logic       single_shot;
    logic [1:0] rsv_hi;
    logic [1:0] fault_count_field;
    logic       alert_sense_select;
    logic       event_latch_select;
    logic       sleep_select;
    logic [1:0] sample_rate_field;
    logic       threshold_flag;
    logic       spare_bit;
    logic [3:0] rsv_lo;
  } tsrf_setup_t;

  // serial slave states, one-hot
  typedef enum logic [4:0] {
    TS_IDLE = 5'h01,
    TS_RX   = 5'h02,
    TS_ACK  = 5'h04,
    TS_TX   = 5'h08,
    TS_RACK = 5'h10
  } tsrf_state_t;

endpackage

//--- rtl/tsrf_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tsrf_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk_i,  // device clock
  input  wire logic         rst_n_i,    // async reset, active low
  input  wire logic [W-1:0] pin_i,      // raw pin levels
  output logic      [W-1:0] lvl_o       // filtered levels
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_d;

  // a change counts only once stages two and three agree
  always_comb begin
    lvl_d = lvl_o;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      lvl_o <= RST_VAL;
    end else begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_o <= lvl_d;
    end
  end
endmodule

//--- test/tsrf_host_model.sv
// serial bus host model: drives the clock and pulls the open-drain data line
`timescale 1ns/1ps
module tsrf_host_model (
  input  wire logic sys_clk_i,  // device clock
  input  wire logic sda_i,      // resolved data wire
  output logic      scl_o,      // serial clock, idle high
  output logic      sda_oe_o    // high pulls data low
);
  localparam int H = 12;  // half bit, kept above the 8-clock minimum

  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // data set while clock low, sampled mid high; released lines float to the pull-up
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o <= ~b;
    hw(H);
    scl_o <= 1'b1;
    hw(H / 2);
    r = sda_i;
    hw(H / 2);
    scl_o <= 1'b0;
    hw(2);
  endtask

  task automatic start_c();
    sda_oe_o <= 1'b1;
    hw(H);
    scl_o <= 1'b0;
    hw(2);
  endtask

  task automatic stop_c();
    sda_oe_o <= 1'b1;
    hw(H);
    scl_o <= 1'b1;
    hw(H);
    sda_oe_o <= 1'b0;
    hw(H);
  endtask

  // eight bits then the acknowledge slot; last=1 releases that slot
  task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(last, r);
    ack = ~r;
  endtask

  // address, pointer, then optional upper and lower byte
  task automatic wr(input logic [7:0] adr, input logic [7:0] ptr, input logic pay,
                    input logic [15:0] wd, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    a2 = 1'b1;
    a3 = 1'b1;
    start_c();
    byte_x(adr, 1'b1, q, a0);
    byte_x(ptr, 1'b1, q, a1);
    if (pay) begin
      byte_x(wd[15:8], 1'b1, q, a2);
      byte_x(wd[7:0], 1'b1, q, a3);
    end
    stop_c();
    ok = a0 & a1 & a2 & a3;
  endtask

  // read of the register chosen by the stored pointer, nack after the low byte
  task automatic rd(input logic [7:0] adr, output logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic       a;
    start_c();
    byte_x(adr, 1'b1, q, ok);
    byte_x(8'hff, 1'b0, q, a);
    d[15:8] = q;
    byte_x(8'hff, 1'b1, q, a);
    d[7:0] = q;
    stop_c();
  endtask
endmodule

//--- test/temp_sensor_register_file_tb_top.sv
// self-checking bench for the sensor register file over the serial bus
`timescale 1ns/1ps
`include "tsrf_regs.svh"
module temp_sensor_register_file_tb_top
  import tsrf_pkg::*;
;
  logic        sys_clk;
  logic        rst_n;
  logic        thr_flag;
  logic        scl;
  logic        host_oe;
  logic        dev_oe;
  logic        busy;
  logic        addr_sel;
  logic [15:0] adc;
  logic        dev_do;
  logic        ok;
  logic [15:0] d;
  logic [15:0] low_q;
  logic [15:0] high_q;
  tsrf_setup_t setup;
  int          miscompares;
  int          num_checks;
  int          n;
  wire logic   sda = ~((dev_oe & ~dev_do) | host_oe);  // pull-up unless someone pulls low

  tsrf_top #(.CONV_CYC(20), .PER0_CYC(400), .PER1_CYC(200), .PER2_CYC(80), .PER3_CYC(60))
  u_tsrf_top (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(dev_do),
    .sda_oe_o(dev_oe), .addr_sel_i(addr_sel), .adc_result_i(adc), .thr_flag_i(thr_flag),
    .setup_o(setup), .low_limit_o(low_q), .high_limit_o(high_q), .conv_busy_o(busy));

  tsrf_host_model u_tsrf_host_model (.sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(host_oe));

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // cycles until the next rising edge of busy, bounded; sampled clear of the launch edge
  task automatic rise(output int c);
    c = 0;
    while (busy !== 1'b0 && c < 5000) begin
      @(negedge sys_clk);
      c++;
    end
    while (busy !== 1'b1 && c < 5000) begin
      @(negedge sys_clk);
      c++;
    end
    @(posedge sys_clk);
  endtask

  // pointer write, then two reads without rewriting it
  task automatic rd2(input logic [7:0] p, input logic [15:0] exp);
    u_tsrf_host_model.wr(8'h56, p, 1'b0, 16'h0000, ok);
    u_tsrf_host_model.rd(8'h57, d, ok);
    chk(d, exp);
    u_tsrf_host_model.rd(8'h57, d, ok);
    chk(d, exp);
  endtask

  initial begin
    logic [15:0] lim [2];
    int          per [4];
    lim = '{16'h1234, 16'habcd};
    per = '{400, 200, 80, 60};
    rst_n = 1'b0;
    thr_flag = 1'b1;
    addr_sel = 1'b1;
    adc = 16'h1230;
    repeat (12) @(posedge sys_clk);
    chk(setup, `TSRF_SETUP_RST);
    chk(low_q, `TSRF_LOW_RST);
    chk(high_q, `TSRF_HIGH_RST);
    rst_n <= 1'b1;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk({15'h0, n >= 19 && n <= 27}, 16'h0001);
    repeat (5) @(posedge sys_clk);
    // pointer bits above the low two are junk and must be dropped
    rd2(8'hfc, 16'h1230);
    rd2(8'hfd, `TSRF_SETUP_RST);
    rd2(8'h02, `TSRF_LOW_RST);
    rd2(8'h03, `TSRF_HIGH_RST);
    u_tsrf_host_model.wr(8'h56, 8'h00, 1'b1, 16'hffff, ok);
    rd2(8'h00, 16'h1230);
    for (int i = 0; i < 2; i++) begin
      u_tsrf_host_model.wr(8'h56, 8'h02 + 8'(i), 1'b1, lim[i], ok);
      chk(i == 0 ? low_q : high_q, lim[i]);
      rd2(8'h02 + 8'(i), lim[i]);
    end
    // reserved bits and the flag ignore the write; bit 4 kept zero
    thr_flag <= 1'b0;
    u_tsrf_host_model.wr(8'h56, 8'h01, 1'b1, 16'h7eef, ok);
    chk(setup, 16'h5ec0);
    rd2(8'h01, 16'h5ec0);
    // wrong address gets no acknowledge
    u_tsrf_host_model.wr(8'h54, 8'h01, 1'b1, 16'h0000, ok);
    chk({15'h0, ok}, 16'h0000);
    // strap low moves the device to the even address
    addr_sel <= 1'b0;
    repeat (8) @(posedge sys_clk);
    u_tsrf_host_model.wr(8'h54, 8'h01, 1'b1, 16'h0000, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(setup, 16'h4000);
    addr_sel <= 1'b1;
    repeat (8) @(posedge sys_clk);
    for (int r = 0; r < 4; r++) begin
      u_tsrf_host_model.wr(8'h56, 8'h01, 1'b1, {8'h00, 2'(r), 6'h00}, ok);
      rise(n);
      rise(n);
      chk(16'(n), 16'(per[r]));
    end
    // a fresh converter word shows up after the next conversion
    adc <= 16'h0a50;
    rd2(8'h00, 16'h0a50);
    // sleep with single shot: one conversion, then the shot bit drops
    adc <= 16'h0c80;
    u_tsrf_host_model.wr(8'h56, 8'h01, 1'b1, 16'h8100, ok);
    chk(setup, 16'h4100);
    chk({15'h0, busy}, 16'h0000);
    adc <= 16'h0d00;
    rd2(8'h00, 16'h0c80);
    give_verdict();
  end

  // run needs about 32k cycles; cut off well beyond that
  initial begin
    #(25 * 80000);
    miscompares++;
    give_verdict();
  end
endmodule
